// ### logic/coil_cmd_pkg.sv
// constants for the coil teach and jog command interpreter
// ==========================================================
// Summary of operation
// - teach mode plus capture on latches position
// - capture goes to slot register's position number
// - empty slot fields get defaults on capture
// - capture held 20ms unhomed raises alarm 093
// - address is axis plus one, 00 broadcast
// - function code 05 single coil write accepted
// - coils 0415/0416, data FF00 on, 0000 off
// - eight byte frame, CRC16, silent gaps around
// - successful non-broadcast write echoes the query unchanged
// - jog mode: on jogs away from home
// - off, or jog-negative on, stops jog
// - inch mode: rising edge starts one inch
// - coil 0414 selects teach or positioning mode
package coil_cmd_pkg;
  // ==========================================================
  // frame layout and coding
  localparam logic [7:0] ADDR_BROADCAST = 8'h00;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'h10;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [15:0] COIL_TEACH_MODE = 16'h0414;
  localparam logic [15:0] COIL_CAPTURE = 16'h0415;
  localparam logic [15:0] COIL_JOG_POS = 16'h0416;
  localparam logic [15:0] COIL_JOG_NEG = 16'h0417;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  localparam logic [3:0] FRAME_BYTES = 4'h8;
  localparam logic [3:0] FRAME_OVER = 4'h9;
  localparam logic [2:0] LAST_BYTE = 3'h7;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // ==========================================================
  // actuator side codes
  localparam logic [7:0] ALARM_HOME_INCOMPLETE = 8'h5d;
  localparam logic [7:0] JOG_SPEED_PARAM = 8'h1a;
  localparam logic [7:0] INCH_DIST_PARAM = 8'h30;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int HOLD_MS = 20;
  localparam int HOLD_CYCLES_DEFAULT = HOLD_MS * (CLK_HZ / 1000);
  localparam int HOLD_CNT_W = 20;
  // ==========================================================
  // register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_SLOT = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_MASK = 12'h00c;
  localparam logic [11:0] REG_STATE = 12'h010;
  localparam logic [11:0] REG_CAPPOS = 12'h014;
  localparam int CTRL_INCH_BIT = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam logic [7:0] SLAVE_ADDR_RESET = 8'h01;
  localparam int STATUS_W = 7;
  localparam int ST_CAPTURE = 0;
  localparam int ST_ALARM = 1;
  localparam int ST_JOG_START = 2;
  localparam int ST_JOG_STOP = 3;
  localparam int ST_INCH = 4;
  localparam int ST_DROP = 5;
  localparam int ST_ECHO = 6;
  typedef enum logic [1:0] {
    S_RX = 2'b01,
    S_TX = 2'b10
  } link_state_t;
endpackage

// ### logic/coil_teach_and_jog_commands.sv
// coil write interpreter for position capture and jog positive
`timescale 1ns/100ps
`default_nettype none
module coil_teach_and_jog_commands
  import coil_cmd_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYCLES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_gap,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] present_position,
  input wire logic [3:0] slot_field_empty,
  input wire logic home_done,
  output logic capture_strobe,
  output logic [7:0] capture_slot,
  output logic [31:0] capture_position,
  output logic [3:0] capture_fill,
  output logic teach_mode,
  output logic jog_run,
  output logic jog_stop,
  output logic inch_start,
  output logic [7:0] speed_param,
  output logic [7:0] distance_param,
  output logic alarm,
  output logic [7:0] alarm_code,
  output logic irq
);
  // ==========================================================
  // state
  typedef struct packed {
    link_state_t st;
    logic [7:0][7:0] frame;
    logic [3:0] rx_cnt;
    logic [15:0] crc;
    logic [2:0] tx_idx;
    logic [7:0] tx_data;
    logic tx_valid;
    logic teach_mode;
    logic capture_coil;
    logic jog_coil;
    logic jog_run;
    logic inch_mode;
    logic [7:0] slave_addr;
    logic [7:0] slot;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic irq;
    logic capture_strobe;
    logic [7:0] capture_slot;
    logic [31:0] capture_position;
    logic [3:0] capture_fill;
    logic jog_stop;
    logic inch_start;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] speed_param;
    logic [7:0] distance_param;
    logic [7:0] alarm_code;
  } regs_t;

  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(HOLD_CYCLES - 1);
  localparam logic [HOLD_CNT_W-1:0] HOLD_FULL = HOLD_CNT_W'(HOLD_CYCLES);

  regs_t r;
  regs_t next_r;
  logic [7:0] f_addr;
  logic [7:0] f_func;
  logic [15:0] f_coil;
  logic [15:0] f_data;
  logic is_on;
  logic frame_good;
  logic exec;
  logic drop;
  logic setup;
  logic wr;
  logic mapped;
  logic [STATUS_W-1:0] ev;
  logic [STATUS_W-1:0] clr;

  // modbus crc, lsb first; running it over the crc bytes too leaves zero
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      if (x[0]) begin
        x = (x >> 1) ^ CRC_POLY;
      end else begin
        x = x >> 1;
      end
    end
    return x;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.capture_strobe = 1'b0;
    next_r.jog_stop = 1'b0;
    next_r.inch_start = 1'b0;
    next_r.pready = 1'b0;
    ev = '0;
    clr = '0;
    f_addr = r.frame[0];
    f_func = r.frame[1];
    f_coil = {r.frame[2], r.frame[3]};
    f_data = {r.frame[4], r.frame[5]};
    is_on = (f_data == COIL_ON);
    frame_good = (r.rx_cnt == FRAME_BYTES) && (r.crc == CRC_RESIDUE)
      && (f_addr == r.slave_addr || f_addr == ADDR_BROADCAST)
      && (f_func == FC_WRITE_COIL)
      && (f_data == COIL_ON || f_data == COIL_OFF)
      && (f_coil == COIL_TEACH_MODE || f_coil == COIL_CAPTURE
          || f_coil == COIL_JOG_POS || f_coil == COIL_JOG_NEG);
    exec = (r.st == S_RX) && rx_gap && frame_good;
    drop = (r.st == S_RX) && rx_gap && (r.rx_cnt != 4'h0) && !frame_good;

    // receive; a byte landing in the same cycle as the gap is lost
    if (r.st == S_RX) begin
      if (rx_gap) begin
        next_r.rx_cnt = 4'h0;
        next_r.crc = CRC_INIT;
      end else if (rx_valid) begin
        if (r.rx_cnt < FRAME_BYTES) begin
          next_r.frame[r.rx_cnt[2:0]] = rx_data;
          next_r.rx_cnt = r.rx_cnt + 4'h1;
          next_r.crc = crc_byte(r.crc, rx_data);
        end else begin
          next_r.rx_cnt = FRAME_OVER;
        end
      end
    end

    if (exec) begin
      unique case (f_coil)
        COIL_TEACH_MODE: begin
          next_r.teach_mode = is_on;
        end
        COIL_CAPTURE: begin
          next_r.capture_coil = is_on;
          if (is_on && r.teach_mode) begin
            next_r.capture_strobe = 1'b1;
            next_r.capture_position = present_position;
            next_r.capture_slot = r.slot;
            next_r.capture_fill = slot_field_empty;
            ev[ST_CAPTURE] = 1'b1;
          end
        end
        COIL_JOG_POS: begin
          next_r.jog_coil = is_on;
          if (is_on) begin
            if (!r.inch_mode) begin
              if (!r.jog_run) begin
                next_r.jog_run = 1'b1;
                ev[ST_JOG_START] = 1'b1;
              end
            end else if (!r.jog_coil) begin
              next_r.inch_start = 1'b1;
              ev[ST_INCH] = 1'b1;
            end
          end else if (r.jog_run) begin
            next_r.jog_run = 1'b0;
            next_r.jog_stop = 1'b1;
            ev[ST_JOG_STOP] = 1'b1;
          end
        end
        default: begin
          if (is_on && r.jog_run) begin
            next_r.jog_run = 1'b0;
            next_r.jog_stop = 1'b1;
            ev[ST_JOG_STOP] = 1'b1;
          end
        end
      endcase
      // broadcasts are obeyed but never answered, else axes would collide
      if (f_addr != ADDR_BROADCAST) begin
        next_r.st = S_TX;
        next_r.tx_idx = 3'h0;
        next_r.tx_data = r.frame[0];
        next_r.tx_valid = 1'b1;
        ev[ST_ECHO] = 1'b1;
      end
    end
    ev[ST_DROP] = drop;

    // echo; receive is deaf meanwhile, the line is half duplex
    if (r.st == S_TX && r.tx_valid && tx_ready) begin
      if (r.tx_idx == LAST_BYTE) begin
        next_r.tx_valid = 1'b0;
        next_r.st = S_RX;
      end else begin
        next_r.tx_idx = r.tx_idx + 3'h1;
        next_r.tx_data = r.frame[r.tx_idx + 3'h1];
      end
    end

    // hold window, saturates so the alarm fires once per hold
    if (r.capture_coil && !home_done) begin
      if (r.hold_cnt != HOLD_FULL) begin
        next_r.hold_cnt = r.hold_cnt + 1'b1;
      end
      if (r.hold_cnt == HOLD_LAST) begin
        ev[ST_ALARM] = 1'b1;
      end
    end else begin
      next_r.hold_cnt = '0;
    end

    // apb: data chosen in setup, answered in a single access cycle
    setup = psel && !penable;
    wr = psel && penable && r.pready && pwrite;
    mapped = (paddr == REG_CTRL) || (paddr == REG_SLOT) || (paddr == REG_STATUS)
      || (paddr == REG_MASK) || (paddr == REG_STATE) || (paddr == REG_CAPPOS);
    if (setup) begin
      next_r.pready = 1'b1;
      next_r.pslverr = !mapped;
      next_r.prdata = '0;
      unique case (paddr)
        REG_CTRL: begin
          next_r.prdata[CTRL_INCH_BIT] = r.inch_mode;
          next_r.prdata[CTRL_ADDR_LSB +: 8] = r.slave_addr;
        end
        REG_SLOT: next_r.prdata[7:0] = r.slot;
        REG_STATUS: next_r.prdata[STATUS_W-1:0] = r.status;
        REG_MASK: next_r.prdata[STATUS_W-1:0] = r.mask;
        REG_STATE: next_r.prdata[3:0] = {r.jog_run, r.jog_coil, r.capture_coil, r.teach_mode};
        REG_CAPPOS: next_r.prdata = r.capture_position;
        default: next_r.prdata = '0;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        REG_CTRL: begin
          next_r.inch_mode = pwdata[CTRL_INCH_BIT];
          // an out of range axis address would make the node unreachable
          if (pwdata[CTRL_ADDR_LSB +: 8] >= ADDR_MIN && pwdata[CTRL_ADDR_LSB +: 8] <= ADDR_MAX) begin
            next_r.slave_addr = pwdata[CTRL_ADDR_LSB +: 8];
          end
        end
        REG_SLOT: next_r.slot = pwdata[7:0];
        REG_STATUS: clr = pwdata[STATUS_W-1:0];
        REG_MASK: next_r.mask = pwdata[STATUS_W-1:0];
        default: next_r.mask = r.mask;
      endcase
    end
    // a new event beats a clear in the same cycle
    next_r.status = (r.status & ~clr) | ev;
    next_r.irq = |(next_r.status & next_r.mask);
    next_r.speed_param = JOG_SPEED_PARAM;
    next_r.distance_param = INCH_DIST_PARAM;
    next_r.alarm_code = ALARM_HOME_INCOMPLETE;
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= S_RX;
      r.crc <= CRC_INIT;
      r.slave_addr <= SLAVE_ADDR_RESET;
      r.speed_param <= JOG_SPEED_PARAM;
      r.distance_param <= INCH_DIST_PARAM;
      r.alarm_code <= ALARM_HOME_INCOMPLETE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign tx_data = r.tx_data;
  assign tx_valid = r.tx_valid;
  assign capture_strobe = r.capture_strobe;
  assign capture_slot = r.capture_slot;
  assign capture_position = r.capture_position;
  assign capture_fill = r.capture_fill;
  assign teach_mode = r.teach_mode;
  assign jog_run = r.jog_run;
  assign jog_stop = r.jog_stop;
  assign inch_start = r.inch_start;
  assign speed_param = r.speed_param;
  assign distance_param = r.distance_param;
  assign alarm = r.status[ST_ALARM];
  assign alarm_code = r.alarm_code;
  assign irq = r.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_capture_on;
    exec && f_coil == COIL_CAPTURE && is_on;
  endsequence
  sequence s_jog_on;
    exec && f_coil == COIL_JOG_POS && is_on;
  endsequence
  sequence s_jog_halt;
    exec && r.jog_run && ((f_coil == COIL_JOG_POS && !is_on)
      || (f_coil == COIL_JOG_NEG && is_on));
  endsequence

  a_capture_latch: assert property (s_capture_on ##0 r.teach_mode |=> capture_strobe
    && capture_position == $past(present_position) && capture_slot == $past(r.slot))
    else $error("capture did not latch position into slot");
  a_capture_gated: assert property (s_capture_on ##0 !r.teach_mode |=> !capture_strobe)
    else $error("capture outside teach mode");
  a_capture_fill: assert property (capture_strobe |-> capture_fill == $past(slot_field_empty))
    else $error("default fill mask wrong");
  a_alarm_window: assert property (r.capture_coil && !home_done && r.hold_cnt == HOLD_LAST
    |=> alarm) else $error("alarm missing after hold window");
  a_alarm_cause: assert property ($rose(alarm) |-> $past(r.hold_cnt) == HOLD_LAST)
    else $error("alarm raised before hold window");
  a_echo_first: assert property (exec && f_addr != ADDR_BROADCAST
    |=> tx_valid && tx_data == $past(r.frame[0])) else $error("echo does not start");
  a_broadcast_quiet: assert property (exec && f_addr == ADDR_BROADCAST |=> !tx_valid)
    else $error("broadcast answered");
  a_drop_silent: assert property (drop |=> !tx_valid && $stable(jog_run) && !capture_strobe)
    else $error("bad frame acted upon");
  a_bad_function: assert property (rx_gap && r.st == S_RX && f_func != FC_WRITE_COIL
    |=> !tx_valid) else $error("foreign function code accepted");
  a_jog_start: assert property (s_jog_on ##0 !r.inch_mode |=> jog_run [*2])
    else $error("jog did not start");
  a_jog_halt: assert property (s_jog_halt |=> !jog_run && jog_stop ##1 !jog_stop)
    else $error("jog did not stop");
  a_inch_edge: assert property (s_jog_on ##0 r.inch_mode |=> inch_start == !$past(r.jog_coil))
    else $error("inch not on rising edge only");
  a_teach_coil: assert property (exec && f_coil == COIL_TEACH_MODE
    |=> teach_mode == $past(is_on)) else $error("teach mode coil ignored");
  a_frame_len: assert property (rx_gap && r.st == S_RX && (r.rx_cnt != FRAME_BYTES
    || r.crc != CRC_RESIDUE) |=> !tx_valid && $stable(jog_run) && !capture_strobe)
    else $error("frame with wrong length or crc acted upon");
endmodule
`default_nettype wire

// ### sim/modbus_host.sv
// serial master model: sends coil write frames and gathers the echo
`timescale 1ns/100ps
`default_nettype none
module modbus_host (
  input wire logic pclk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_gap,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic sending = 1'b0;
  logic bad_fc = 1'b0;
  logic [63:0] frame = 64'h0;
  logic [63:0] echo_w = 64'h0;
  int n_echo = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_gap = 1'b0;
    tx_ready = 1'b1;
  end
  // ==========================================================
  // echo side: a slow master stalls every other cycle
  always @(posedge pclk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid === 1'b1 && tx_ready) begin
      echo_w <= {echo_w[55:0], tx_data};
      n_echo <= n_echo + 1;
    end
    // an idle line never repeats the last byte, so stale data cannot pass as good
    if (!sending) rx_data <= ~rx_data;
  end
  // ==========================================================
  // modbus crc, low byte sent first
  function automatic logic [15:0] crc16(input logic [47:0] h);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 5; i >= 0; i--) begin
      c = c ^ {8'h00, h[i*8 +: 8]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] a, input logic [15:0] c, input logic [15:0] d,
      input bit bad);
    logic [15:0] k;
    logic [7:0] fc;
    int t;
    // a foreign function code still carries a good crc, so only the code can refuse it
    fc = bad_fc ? 8'h06 : 8'h05;
    k = crc16({a, fc, c, d});
    frame = {a, fc, c, d, k[7:0] ^ {7'h0, bad}, k[15:8]};
    n_echo = 0;
    t = 0;
    sending = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(posedge pclk);
      rx_data <= frame[i*8 +: 8];
      rx_valid <= 1'b1;
    end
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_gap <= 1'b1;
    @(posedge pclk);
    rx_gap <= 1'b0;
    sending = 1'b0;
    repeat (2) @(posedge pclk);
    while (tx_valid === 1'b1 && t < 100) begin
      @(posedge pclk);
      t++;
    end
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
endmodule
`default_nettype wire

// ### sim/tb_coil_teach_and_jog_commands.sv
// self-checking bench for the coil teach and jog command interpreter
`timescale 1ns/100ps
`default_nettype none
module tb_coil_teach_and_jog_commands;
  import coil_cmd_pkg::*;
  localparam int HOLD = 50;
  localparam logic [31:0] SEQ [11] = '{32'h0416ff00, 32'h0416ff00, 32'h04160000, 32'h0416ff00,
    32'h0417ff00, 32'h04170000, 32'h04160000, 32'h0416ff00, 32'h0416ff00, 32'h04160000,
    32'h0416ff00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, present_position = 32'h0, prdata, capture_position;
  logic [3:0] slot_field_empty = 4'h0, capture_fill;
  logic home_done = 1'b1, pready, pslverr, tx_valid, tx_ready, rx_valid, rx_gap;
  logic [7:0] rx_data, tx_data, capture_slot, speed_param, distance_param, alarm_code;
  logic capture_strobe, teach_mode, jog_run, jog_stop, inch_start, alarm, irq;
  logic [31:0] rd, rnd = 32'h0318, cur_pos = 32'h0, e_pos = 32'h0;
  logic [7:0] cur_slot = 8'h00, e_slot = 8'h00;
  logic [3:0] cur_empty = 4'h0, e_fill = 4'h0;
  int fails = 0, checks = 0, cyc = 0, n_cap = 0, n_stop = 0, n_ich = 0;
  int m_teach = 0, m_cap = 0, m_run = 0, m_stop = 0, m_ich = 0, m_jp = 0, m_inch = 0;
  coil_teach_and_jog_commands #(.HOLD_CYCLES(HOLD)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_gap(rx_gap), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .present_position(present_position),
    .slot_field_empty(slot_field_empty), .home_done(home_done),
    .capture_strobe(capture_strobe), .capture_slot(capture_slot),
    .capture_position(capture_position), .capture_fill(capture_fill),
    .teach_mode(teach_mode), .jog_run(jog_run), .jog_stop(jog_stop),
    .inch_start(inch_start), .speed_param(speed_param), .distance_param(distance_param),
    .alarm(alarm), .alarm_code(alarm_code), .irq(irq));
  modbus_host host (.pclk(pclk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_gap(rx_gap),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  always #20 pclk = ~pclk;
  // ==========================================================
  // pulse counters and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (capture_strobe === 1'b1) n_cap <= n_cap + 1;
    if (jog_stop === 1'b1) n_stop <= n_stop + 1;
    if (inch_start === 1'b1) n_ich <= n_ich + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rd = pslverr === 1'b1 ? 32'hdead0bad : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask
  // ==========================================================
  // one coil write through the master, then the model is compared with the ports
  task automatic cmd(input logic [7:0] a, input logic [15:0] c, input logic [15:0] d,
      input bit bad);
    bit good;
    bit on;
    good = !bad && !host.bad_fc && (a == 8'h01 || a == 8'h00) && (d == COIL_ON || d == COIL_OFF);
    on = d == COIL_ON;
    host.send(a, c, d, bad);
    if (good && c == COIL_TEACH_MODE) m_teach = on;
    if (good && c == COIL_CAPTURE && on && m_teach) begin
      m_cap++;
      e_slot = cur_slot;
      e_pos = cur_pos;
      e_fill = cur_empty;
    end
    if (good && c == COIL_JOG_POS) begin
      if (!m_inch && on && !m_run) m_run = 1;
      if (!m_inch && !on && m_run) begin
        m_run = 0;
        m_stop++;
      end
      if (m_inch && on && !m_jp) m_ich++;
      m_jp = on;
    end
    if (good && c == COIL_JOG_NEG && on && m_run) begin
      m_run = 0;
      m_stop++;
    end
    chk("echo_count", (good && a != 8'h00) ? 8 : 0, host.n_echo);
    if (good && a != 8'h00) begin
      chk("echo_hi", host.frame[63:32], host.echo_w[63:32]);
      chk("echo_lo", host.frame[31:0], host.echo_w[31:0]);
    end
    chk("teach_mode", 32'(teach_mode), m_teach);
    chk("captures", m_cap, n_cap);
    chk("capture_slot", 32'(e_slot), 32'(capture_slot));
    chk("capture_position", e_pos, capture_position);
    chk("capture_fill", 32'(e_fill), 32'(capture_fill));
    chk("jog_run", m_run, 32'(jog_run));
    chk("jog_stops", m_stop, n_stop);
    chk("inch_starts", m_ich, n_ich);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("speed_param", 32'h1a, 32'(speed_param));
    chk("distance_param", 32'h30, 32'(distance_param));
    chk("alarm_code", 32'h5d, 32'(alarm_code));
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_reset", 32'h100, rd);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'hdead0bad, rd);
    apb(1'b1, REG_MASK, 32'h22);
    $display("test reset done");
    cmd(8'h01, COIL_CAPTURE, COIL_ON, 1'b0);
    cmd(8'h01, COIL_CAPTURE, COIL_OFF, 1'b0);
    cmd(8'h01, COIL_TEACH_MODE, COIL_ON, 1'b0);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      cur_slot = rnd[7:0];
      cur_empty = rnd[11:8];
      cur_pos = {rnd[15:0], rnd[31:16]};
      @(posedge pclk);
      present_position <= cur_pos;
      slot_field_empty <= cur_empty;
      apb(1'b1, REG_SLOT, {24'h0, cur_slot});
      cmd(i == 2 ? 8'h00 : 8'h01, COIL_CAPTURE, COIL_ON, 1'b0);
      repeat (HOLD + 5) @(posedge pclk);
      cmd(8'h01, COIL_CAPTURE, COIL_OFF, 1'b0);
      apb(1'b0, REG_CAPPOS, 32'h0);
      chk("cappos", cur_pos, rd);
    end
    chk("alarm_homed", 32'h0, 32'(alarm));
    $display("test capture done");
    @(posedge pclk);
    home_done <= 1'b0;
    cmd(8'h01, COIL_CAPTURE, COIL_ON, 1'b0);
    chk("alarm_early", 32'h0, 32'(alarm));
    repeat (HOLD) @(posedge pclk);
    @(negedge pclk);
    chk("alarm_set", 32'h1, 32'(alarm));
    chk("irq_set", 32'h1, 32'(irq));
    apb(1'b1, REG_STATUS, 32'h7f);
    chk("irq_clear", 32'h0, 32'(irq));
    cmd(8'h01, COIL_CAPTURE, COIL_OFF, 1'b0);
    @(posedge pclk);
    home_done <= 1'b1;
    $display("test alarm done");
    cmd(8'h01, COIL_JOG_POS, COIL_ON, 1'b1);
    cmd(8'h02, COIL_JOG_POS, COIL_ON, 1'b0);
    host.bad_fc = 1'b1;
    cmd(8'h01, COIL_JOG_POS, COIL_ON, 1'b0);
    host.bad_fc = 1'b0;
    cmd(8'h01, COIL_JOG_POS, 16'h1234, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("drop_flag", 32'h1, 32'(rd[ST_DROP]));
    chk("irq_drop", 32'h1, 32'(irq));
    apb(1'b1, REG_STATUS, 32'h7f);
    $display("test drop done");
    // stalled echo side here, so the echo must survive backpressure
    host.slow = 1'b1;
    apb(1'b1, REG_CTRL, 32'h100);
    for (int i = 0; i < 11; i++) begin
      if (i == 7) begin
        apb(1'b1, REG_CTRL, 32'h101);
        m_inch = 1;
      end
      cmd(8'h01, SEQ[i][31:16], SEQ[i][15:0], 1'b0);
    end
    $display("test jog done");
    test_done();
  end
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
endmodule
`default_nettype wire
